// *** sgc_gateway.v ***
// Network command to framed serial gateway with response timeout
`timescale 1ns/1ps
`include "sgc_regs.vh"
module sgc_gateway #(
	parameter TICK_CYCLES = `SGC_TICK_CYCLES
) (
	input wire mclk,
	input wire rst,
	input wire gateway_en,
	input wire [7:0] tmo_setting,
	input wire [7:0] dest_unit_addr,
	input wire [7:0] main_request_code,
	input wire [7:0] sub_request_code,
	input wire cmd_start,
	output wire cmd_start_ready,
	input wire [7:0] pay_data,
	input wire pay_valid,
	input wire pay_last,
	output wire pay_ready,
	output wire [7:0] ser_data,
	output wire ser_valid,
	input wire ser_ready,
	output reg ser_port_sel,
	input wire ser_reply,
	output reg rsp_valid,
	output reg [15:0] rsp_end_code,
	output reg cmd_reject,
	output reg busy
);
	localparam S_IDLE = 3'd0;
	localparam S_STX = 3'd1;
	localparam S_PAY = 3'd2;
	localparam S_ETX = 3'd3;
	localparam S_BCC = 3'd4;
	localparam S_WAIT = 3'd5;
	localparam S_LATE = 3'd6;
	reg [2:0] state;
	reg [7:0] check;
	reg [7:0] limit;
	reg [7:0] tenths;
	reg [31:0] tick;
	reg [8:0] b_in;
	reg b_in_valid;
	wire b_in_ready;
	wire [8:0] b_out;
	wire valid_cmd;
	wire unit_ok;
	wire code_ok;
	assign code_ok = (main_request_code == `SGC_CMD_MAIN) &&
		(sub_request_code == `SGC_CMD_SUB);
	assign unit_ok = (dest_unit_addr == `SGC_UNIT_PERIPH) ||
		(dest_unit_addr == `SGC_UNIT_RS232);
	assign valid_cmd = code_ok && unit_ok && gateway_en;
	assign cmd_start_ready = (state == S_IDLE);
	assign pay_ready = (state == S_PAY) && b_in_ready;
	// Frame bytes pass through the buffer; bit 8 marks the last payload byte and the check byte that ends the frame
	always @* begin
		b_in = 9'h000;
		b_in_valid = 1'b0;
		case (state)
		S_STX: begin
			b_in = {1'b0, `SGC_STX};
			b_in_valid = 1'b1;
		end
		S_PAY: begin
			b_in = {pay_last, pay_data};
			b_in_valid = pay_valid;
		end
		S_ETX: begin
			b_in = {1'b0, `SGC_ETX};
			b_in_valid = 1'b1;
		end
		S_BCC: begin
			b_in = {1'b1, check ^ `SGC_ETX};
			b_in_valid = 1'b1;
		end
		default: begin
			b_in = 9'h000;
			b_in_valid = 1'b0;
		end
		endcase
	end
	sgc_buf2 #(.W(9)) u_buf (
		.mclk(mclk),
		.rst(rst),
		.in_data(b_in),
		.in_valid(b_in_valid),
		.in_ready(b_in_ready),
		.out_data(b_out),
		.out_valid(ser_valid),
		.out_ready(ser_ready)
	);
	assign ser_data = b_out[7:0];
	wire frame_done = ser_valid && ser_ready && b_out[8] &&
		(state == S_WAIT);
	reg sent;
	always @(posedge mclk) begin
		if (rst) begin
			state <= S_IDLE;
			check <= 8'h00;
			limit <= `SGC_TMO_DEFAULT;
			tenths <= 8'h00;
			tick <= 32'd0;
			sent <= 1'b0;
			ser_port_sel <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_end_code <= 16'h0000;
			cmd_reject <= 1'b0;
			busy <= 1'b0;
		end else begin
			rsp_valid <= 1'b0;
			cmd_reject <= 1'b0;
			case (state)
			S_IDLE: begin
				if (cmd_start) begin
					if (valid_cmd) begin
						state <= S_STX;
						busy <= 1'b1;
						sent <= 1'b0;
						check <= 8'h00;
						ser_port_sel <= (dest_unit_addr ==
							`SGC_UNIT_RS232);
						limit <= (tmo_setting == 8'h00) ?
							`SGC_TMO_DEFAULT : tmo_setting;
					end else begin
						cmd_reject <= 1'b1;
					end
				end
			end
			S_STX: if (b_in_ready) state <= S_PAY;
			S_PAY: begin
				if (pay_valid && b_in_ready) begin
					check <= check ^ pay_data;
					if (pay_last)
						state <= S_ETX;
				end
			end
			S_ETX: if (b_in_ready) state <= S_BCC;
			S_BCC: begin
				if (b_in_ready) begin
					state <= S_WAIT;
					tenths <= 8'h00;
					tick <= 32'd0;
				end
			end
			S_WAIT: begin
				if (frame_done)
					sent <= 1'b1;
				if (sent) begin
					if (ser_reply) begin
						state <= S_IDLE;
						busy <= 1'b0;
						rsp_valid <= 1'b1;
						rsp_end_code <= `SGC_END_OK;
					end else if (tick == TICK_CYCLES - 1) begin
						tick <= 32'd0;
						if (tenths + 8'd1 == limit) begin
							state <= S_LATE;
							rsp_valid <= 1'b1;
							rsp_end_code <= `SGC_END_TIMEOUT;
						end else begin
							tenths <= tenths + 8'd1;
						end
					end else begin
						tick <= tick + 32'd1;
					end
				end
			end
			S_LATE: begin
				state <= S_IDLE;
				busy <= 1'b0;
			end
			default: state <= S_IDLE;
			endcase
		end
	end
endmodule // sgc_gateway

// *** sgc_regs.vh ***
// Constants for the serial gateway converter
`ifndef SGC_REGS_VH
`define SGC_REGS_VH
`define SGC_CMD_MAIN 8'h28
`define SGC_CMD_SUB 8'h03
`define SGC_UNIT_PERIPH 8'hFD
`define SGC_UNIT_RS232 8'hFC
`define SGC_STX 8'h02
`define SGC_ETX 8'h03
`define SGC_END_TIMEOUT 16'h0205
`define SGC_END_OK 16'h0000
`define SGC_TMO_DEFAULT 8'h32
`define SGC_TICK_NS 100000000
`define SGC_CLK_NS 25
`define SGC_TICK_CYCLES (`SGC_TICK_NS / `SGC_CLK_NS)
`endif

// *** sgc_buf2.v ***
// Two-entry valid/ready buffer
`timescale 1ns/1ps
module sgc_buf2 #(
	parameter W = 9
) (
	input wire mclk,
	input wire rst,
	input wire [W-1:0] in_data,
	input wire in_valid,
	output wire in_ready,
	output wire [W-1:0] out_data,
	output wire out_valid,
	input wire out_ready
);
	reg [W-1:0] mem [0:1];
	reg rd_ptr;
	reg wr_ptr;
	reg [1:0] count;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	assign in_ready = (count != 2'd2);
	assign out_valid = (count != 2'd0);
	assign out_data = mem[rd_ptr];
	always @(posedge mclk) begin
		if (rst) begin
			rd_ptr <= 1'b0;
			wr_ptr <= 1'b0;
			count <= 2'd0;
		end else begin
			if (push) begin
				mem[wr_ptr] <= in_data;
				wr_ptr <= ~wr_ptr;
			end
			if (pop)
				rd_ptr <= ~rd_ptr;
			if (push && !pop)
				count <= count + 2'd1;
			else if (pop && !push)
				count <= count - 2'd1;
		end
	end
endmodule // sgc_buf2

// *** sgc_props.sv ***
// Checker for the serial gateway converter ports
`timescale 1ns/1ps
module sgc_props(
	input wire mclk, input wire rst, input wire gateway_en,
	input wire [7:0] dest_unit_addr, input wire [7:0] main_request_code,
	input wire [7:0] sub_request_code, input wire cmd_start,
	input wire cmd_start_ready, input wire [7:0] ser_data,
	input wire ser_valid, input wire ser_ready, input wire ser_port_sel,
	input wire rsp_valid, input wire [15:0] rsp_end_code,
	input wire cmd_reject, input wire busy
);
	wire go = cmd_start && cmd_start_ready;
	wire ok = main_request_code == 8'h28 && sub_request_code == 8'h03;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	a_bad_code: assert property (go && !ok |=> cmd_reject && !busy)
		else $error("bad code taken");
	a_gate_off: assert property (go && !gateway_en |=> cmd_reject)
		else $error("gateway off not refused");
	a_periph_sel: assert property (go && ok && gateway_en &&
		dest_unit_addr == 8'hfd |=> busy && !ser_port_sel) else $error("fd");
	a_rs232_sel: assert property (go && ok && gateway_en &&
		dest_unit_addr == 8'hfc |=> busy && ser_port_sel) else $error("fc");
	a_stx_first: assert property ($rose(busy) |->
		##[0:4] ser_valid && ser_data == 8'h02) else $error("no start byte");
	a_hold_byte: assert property (ser_valid && !ser_ready |=>
		ser_valid && $stable(ser_data)) else $error("byte dropped");
	a_end_code: assert property (rsp_valid |-> rsp_end_code == 16'h0000 ||
		rsp_end_code == 16'h0205) else $error("bad end code");
	a_rsp_idle: assert property (rsp_valid |=> !busy)
		else $error("busy after answer");
	a_no_late: assert property (!busy && !$past(busy) |-> !rsp_valid)
		else $error("answer while idle");
endmodule // sgc_props
bind sgc_gateway sgc_props i_props(.*);

// *** sgc_ser_model.sv ***
// Serially attached component model
`timescale 1ns/1ps
module sgc_ser_model(
	input wire mclk,
	input wire rst,
	input wire late,
	input wire [7:0] ser_data,
	input wire ser_valid,
	output reg ser_ready = 1'b0,
	output reg ser_reply = 1'b0
);
	reg [7:0] q[$];
	reg [1:0] ph = 2'h0;
	reg [7:0] last = 8'h00;
	integer cnt = 0;
	always @(posedge mclk) begin
		ph <= ph + 2'h1;
		ser_ready <= ph != 2'h3; // Stall one cycle in four
		ser_reply <= cnt == 1;
		if (cnt > 0) cnt <= cnt - 1;
		if (ser_valid && ser_ready) begin
			q.push_back(ser_data);
			last <= ser_data;
			if (last == 8'h03) cnt <= late ? 40 : 6; // Reply after check byte
		end
		if (rst) cnt <= 0;
	end
endmodule // sgc_ser_model

// *** tb.sv ***
// Testbench for the serial gateway converter
`timescale 1ns/1ps
module tb;
	reg mclk = 0, rst = 1, gateway_en = 1, cmd_start = 0, late = 0;
	reg pay_valid = 0, pay_last = 0;
	reg [7:0] tmo_setting = 8'h01, dest_unit_addr = 8'h00, pay_data = 8'h00;
	reg [7:0] main_request_code = 8'h00, sub_request_code = 8'h03;
	wire cmd_start_ready, pay_ready, ser_valid, ser_ready, ser_port_sel;
	wire ser_reply, rsp_valid, cmd_reject, busy;
	wire [7:0] ser_data;
	wire [15:0] rsp_end_code;
	integer errors = 0, check_count = 0, nrsp = 0, nrej = 0, i;
	reg [7:0] bcc;
	string p = "010000101";
	sgc_gateway #(.TICK_CYCLES(10)) i_dut(.*);
	sgc_ser_model m(.*);
	initial forever #12.5 mclk = ~mclk;
	always @(posedge mclk) begin
		nrsp <= nrsp + rsp_valid;
		nrej <= nrej + cmd_reject;
	end
	task chk(input [31:0] g, input [31:0] e);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	task end_sim;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task run(input [7:0] mc, input [7:0] un, input pl);
		m.q.delete();
		main_request_code = mc;
		dest_unit_addr = un;
		cmd_start = 1;
		@(negedge mclk) cmd_start = 0;
		for (i = 0; pl && i < 9; i++) begin
			pay_data = p[i];
			pay_valid = 1;
			pay_last = i == 8;
			#1 while (!pay_ready) @(negedge mclk);
			@(negedge mclk);
		end
		pay_valid = 0;
		pay_last = 0;
		for (i = 0; i < 300 && (busy !== 1'b0 || i < 3); i++) @(negedge mclk);
		@(negedge mclk);
	endtask
	task frame;
		bcc = 8'h03;
		chk(m.q.size(), 12);
		chk(m.q[0], 8'h02);
		for (i = 0; i < 9; i++) begin
			chk(m.q[i+1], p[i]);
			bcc ^= p[i];
		end
		chk(m.q[10], 8'h03);
		chk(m.q[11], bcc);
	endtask
	task t_ok;
		run(8'h28, 8'hfd, 1);
		frame;
		chk(nrsp, 1);
		chk(rsp_end_code, 16'h0000);
		chk(ser_port_sel, 0);
		chk(cmd_start_ready, 1);
		$display("test ok done");
	endtask
	task t_tmo;
		late = 1;
		run(8'h28, 8'hfc, 1);
		frame;
		chk(nrsp, 2);
		chk(rsp_end_code, 16'h0205);
		chk(ser_port_sel, 1);
		repeat (60) @(negedge mclk);
		chk(nrsp, 2);
		$display("test timeout done");
	endtask
	task t_dflt;
		tmo_setting = 8'h00;
		run(8'h28, 8'hfd, 1);
		frame;
		chk(nrsp, 3);
		chk(rsp_end_code, 16'h0000);
		$display("test default limit done");
	endtask
	task t_bad;
		run(8'h01, 8'hfd, 0);
		chk(nrej, 1);
		run(8'h28, 8'h10, 0);
		chk(nrej, 2);
		gateway_en = 0;
		run(8'h28, 8'hfd, 0);
		chk(nrej, 3);
		chk(nrsp, 3);
		$display("test reject done");
	endtask
	initial begin
		#50000;
		errors++;
		end_sim;
	end
	initial begin
		repeat (8) @(negedge mclk);
		rst = 0;
		t_ok;
		t_tmo;
		t_dflt;
		t_bad;
		end_sim;
	end
endmodule // tb
